// ===== dv/ips_host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "ips_map.svh"
module ips_host_model
(
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   irq_out_n,
  output ips_pkg::ips_wake_t          clear_wake,
  output logic [`IPS_FAIL_W-1:0]      clear_fail
);
  int   wait_cnt = 0;
  logic last_n   = 1'b1;
  wire  fire     = resetn && wait_cnt == 1;
  // host reads 100 cycles after the pulse falls, then clears every wake and fail bit
  always @(negedge core_clk)
  begin
    last_n     <= irq_out_n;
    clear_wake <= {4{fire}};
    clear_fail <= {`IPS_FAIL_W{fire}};
    if (!resetn || fire)
      wait_cnt <= 0;
    else if (wait_cnt > 1)
      wait_cnt <= wait_cnt - 1;
    else if (last_n === 1'b1 && irq_out_n === 1'b0)
      wait_cnt <= 100;
  end
endmodule
`default_nettype wire

// ===== dv/ips_signaller_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "ips_map.svh"
module ips_signaller_bench;
  localparam ips_pkg::ips_wake_t W_CAN = 4'h8;
  localparam ips_pkg::ips_wake_t W_HV  = 4'h4;
  logic                   core_clk = 1'b0;
  logic                   resetn = 1'b0;
  ips_pkg::ips_mode_t     mode = ips_pkg::IPS_MODE_INIT;
  logic                   class_global = 1'b0;
  ips_pkg::ips_wake_t     wake_enable = '0;
  ips_pkg::ips_wake_t     wake_raw_event = '0;
  logic [`IPS_FAIL_W-1:0] fail_event = '0;
  logic                   hv_wake_input = 1'b0;
  logic                   irq_pin_in = 1'b0;
  ips_pkg::ips_wake_t     clear_wake, wake_status;
  logic [`IPS_FAIL_W-1:0] clear_fail, fail_status;
  logic                   irq_out_n, irq_out_oe, wake_pin_level_status;
  logic                   device_wakeup, hw_config_sel;
  logic                   woke = 1'b0;
  int                     err_count = 0;
  int                     checks_done = 0;
  int                     cyc = 0;
  int                     n;

  ips_signaller dut (.core_clk(core_clk), .resetn(resetn), .mode(mode),
    .class_global(class_global), .wake_enable(wake_enable),
    .wake_raw_event(wake_raw_event), .fail_event(fail_event),
    .hv_wake_input(hv_wake_input), .irq_pin_in(irq_pin_in),
    .clear_wake(clear_wake), .clear_fail(clear_fail),
    .irq_out_n(irq_out_n), .irq_out_oe(irq_out_oe),
    .wake_status(wake_status), .fail_status(fail_status),
    .wake_pin_level_status(wake_pin_level_status),
    .device_wakeup(device_wakeup), .hw_config_sel(hw_config_sel));
  ips_host_model host (.core_clk(core_clk), .resetn(resetn),
    .irq_out_n(irq_out_n), .clear_wake(clear_wake),
    .clear_fail(clear_fail));

  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  // longest path is one pulse plus one gap and a few filter waits
  always @(posedge core_clk)
  begin
    cyc++;
    if (device_wakeup === 1'b1)
      woke = 1'b1;
    if (cyc == 80000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic do_reset();
    resetn = 1'b0;
    tick(6);
    resetn = 1'b1;
  endtask
  task automatic wake_ev(ips_pkg::ips_wake_t w);
    wake_raw_event = w;
    tick(1);
    wake_raw_event = '0;
  endtask
  // count cycles while irq holds a level, optionally injecting a failure
  task automatic run_level(logic lvl);
    n = 0;
    while (irq_out_n === lvl && n < 30000)
    begin
      fail_event = (!lvl && n == 200) ? 8'h01 : 8'h00;
      n++;
      tick(1);
    end
  endtask

  task automatic t_cfg();
    irq_pin_in = 1'b1;
    tick(`IPS_CFG_FILT_CYC + 100);
    chk("hw_config_sel", 1, hw_config_sel);
    chk("irq_out_oe", 0, irq_out_oe);
    $display("cfg strap done");
  endtask
  task automatic t_refuse();
    mode = ips_pkg::IPS_MODE_NORMAL;
    // can, timer and gpio at once, none of them enabled
    wake_ev(4'hB);
    fail_event = 8'h01;
    tick(1);
    fail_event = 8'h00;
    tick(20);
    chk("irq_out_n", 1, irq_out_n);
    chk("irq_out_oe", 1, irq_out_oe);
    $display("refusal done");
  endtask
  task automatic t_stop();
    mode = ips_pkg::IPS_MODE_RESTART;
    wake_enable = W_CAN;
    wake_ev(W_CAN);
    tick(20);
    chk("irq_out_n", 1, irq_out_n);
    mode = ips_pkg::IPS_MODE_STOP;
    n = 0;
    while (irq_out_n !== 1'b0 && n < 10)
    begin
      n++;
      tick(1);
    end
    chk("irq_out_n", 0, irq_out_n);
    do_reset();
    $display("stop entry done");
  endtask
  task automatic t_pulse();
    mode = ips_pkg::IPS_MODE_NORMAL;
    class_global = 1'b1;
    wake_ev(W_CAN);
    chk("irq_out_n", 0, irq_out_n);
    chk("wake_status", W_CAN, wake_status);
    run_level(1'b0);
    chk("pulse cycles", `IPS_PULSE_CYC, n);
    run_level(1'b1);
    chk("gap cycles", `IPS_GAP_CYC, n);
    chk("fail_status", 8'h01, fail_status);
    chk("wake_status", 0, wake_status);
    do_reset();
    $display("pulse and gap done");
  endtask
  task automatic t_hv();
    mode = ips_pkg::IPS_MODE_SLEEP;
    wake_enable = W_HV;
    hv_wake_input = 1'b1;
    tick(100);
    hv_wake_input = 1'b0;
    tick(`IPS_WAKE_FILT_CYC + 50);
    chk("device_wakeup", 0, woke);
    hv_wake_input = 1'b1;
    tick(`IPS_WAKE_FILT_CYC + 50);
    chk("device_wakeup", 1, woke);
    chk("wake_pin_level_status", 1, wake_pin_level_status);
    chk("irq_out_n", 1, irq_out_n);
    mode = ips_pkg::IPS_MODE_FAILSAFE;
    wake_enable = 4'h2;
    wake_ev(4'h2);
    chk("device_wakeup", 1, device_wakeup);
    tick(1);
    chk("device_wakeup", 0, device_wakeup);
    chk("irq_out_n", 1, irq_out_n);
    $display("wake pin filter done");
  endtask

  initial
  begin
    tick(6);
    resetn = 1'b1;
    t_cfg();
    t_refuse();
    t_stop();
    t_pulse();
    t_hv();
    close_out();
  end
endmodule
`default_nettype wire

// ===== hdl/ips_signaller.sv
// Notes on behaviour
// - in normal and stop, irq_out_n pulses low 100 us, then releases
// - at least 100 us high between the end of a pulse and the next
// - an interrupt pulse never changes the operating mode by itself
// - class select 0 means wake-only interrupts, 1 adds failure events
// - a wake interrupt needs its source currently enabled as wake source
// - wake sources: bus wake, hv wake pin, cyclic timer, gpio wake
// - global class adds latched failures; level and id registers never
// - uv, watchdog, short, thermal, fail, por, state field never interrupt
// - no pulse in restart, fail-safe or sleep mode; a pulse already under way when the mode changes runs to its end
// - entering stop with uncleared wake bits raises an interrupt
// - status registers update at each falling edge of the pulse
// - events stay latched until read and cleared; level register is live
// - hv wake input change is qualified by a 16 us filter
// - filter starts at the crossing; any cross back during it cancels
// - in init mode, irq pin level is filtered 10 us to pick configuration
// - both wake input edges signal: interrupt or device wake-up
`timescale 1ns/10ps
`default_nettype none
`include "ips_map.svh"
module ips_signaller
(
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire ips_pkg::ips_mode_t       mode,
  input  wire logic                     class_global,
  input  wire ips_pkg::ips_wake_t       wake_enable,
  input  wire ips_pkg::ips_wake_t       wake_raw_event,
  input  wire logic [`IPS_FAIL_W-1:0]   fail_event,
  input  wire logic                     hv_wake_input,
  input  wire logic                     irq_pin_in,
  input  wire ips_pkg::ips_wake_t       clear_wake,
  input  wire logic [`IPS_FAIL_W-1:0]   clear_fail,
  output logic                          irq_out_n,
  output logic                          irq_out_oe,
  output ips_pkg::ips_wake_t            wake_status,
  output logic [`IPS_FAIL_W-1:0]        fail_status,
  output logic                          wake_pin_level_status,
  output logic                          device_wakeup,
  output logic                          hw_config_sel
);

  localparam logic [`IPS_CNT_W-1:0] PULSE_CYC =
    `IPS_CNT_W'(`IPS_PULSE_CYC);
  localparam logic [`IPS_CNT_W-1:0] GAP_CYC = `IPS_CNT_W'(`IPS_GAP_CYC);
  localparam logic [`IPS_CNT_W-1:0] WFILT_CYC =
    `IPS_CNT_W'(`IPS_WAKE_FILT_CYC);
  localparam logic [`IPS_CNT_W-1:0] CFILT_CYC =
    `IPS_CNT_W'(`IPS_CFG_FILT_CYC);

  default clocking sample_cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // three-stage synchronisers for both pins
  logic [2:0] wk_sync;
  logic [2:0] cfg_sync;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wk_sync  <= 3'h0;
      cfg_sync <= 3'h0;
    end
    else
    begin
      wk_sync  <= {wk_sync[1:0], hv_wake_input};
      cfg_sync <= {cfg_sync[1:0], irq_pin_in};
    end
  end
  wire wk_agree  = wk_sync[1] == wk_sync[2];
  wire cfg_agree = cfg_sync[1] == cfg_sync[2];

  // hv wake filter
  logic                  wk_stable;
  logic [`IPS_CNT_W-1:0] wk_cnt;
  logic                  wk_armed;
  wire wk_cross  = wk_agree && (wk_sync[2] != wk_stable);
  wire wk_done   = wk_armed && wk_cross && (wk_cnt == WFILT_CYC - 1'b1);
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wk_stable <= 1'b0;
      wk_cnt    <= '0;
      wk_armed  <= 1'b0;
    end
    else if (!wk_cross)
    begin
      wk_cnt   <= '0;
      wk_armed <= 1'b0;
    end
    else if (wk_done)
    begin
      wk_stable <= wk_sync[2];
      wk_cnt    <= '0;
      wk_armed  <= 1'b0;
    end
    else
    begin
      wk_cnt   <= wk_cnt + 1'b1;
      wk_armed <= 1'b1;
    end
  end

  // config strap filter, init mode only
  logic [`IPS_CNT_W-1:0] cfg_cnt;
  wire in_init  = mode == ips_pkg::IPS_MODE_INIT;
  wire cfg_diff = cfg_agree && (cfg_sync[2] != hw_config_sel);
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_cnt       <= '0;
      hw_config_sel <= 1'b0;
    end
    else if (!in_init || !cfg_diff)
      cfg_cnt <= '0;
    else if (cfg_cnt == CFILT_CYC - 1'b1)
    begin
      hw_config_sel <= cfg_sync[2];
      cfg_cnt       <= '0;
    end
    else
      cfg_cnt <= cfg_cnt + 1'b1;
  end

  // wake event latching, only enabled sources count
  ips_pkg::ips_wake_t new_wake;
  assign new_wake.can    = wake_raw_event.can    & wake_enable.can;
  assign new_wake.hv_pin = wk_done & wake_enable.hv_pin;
  assign new_wake.timer  = wake_raw_event.timer  & wake_enable.timer;
  assign new_wake.gpio   = wake_raw_event.gpio   & wake_enable.gpio;

  // fail_event excludes reset/fail-safe causes by construction upstream
  logic [`IPS_FAIL_W-1:0] fail_latch;
  ips_pkg::ips_wake_t     wake_latch;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_latch <= '0;
      fail_latch <= '0;
    end
    else
    begin
      // set wins over clear
      wake_latch <= (wake_latch & ~clear_wake) | new_wake;
      fail_latch <= (fail_latch & ~clear_fail) | fail_event;
    end
  end

  wire quiet_mode = mode == ips_pkg::IPS_MODE_RESTART ||
                    mode == ips_pkg::IPS_MODE_FAILSAFE ||
                    mode == ips_pkg::IPS_MODE_SLEEP;
  wire irq_mode   = mode == ips_pkg::IPS_MODE_NORMAL ||
                    mode == ips_pkg::IPS_MODE_STOP;
  wire new_fail_ev = class_global && (|fail_event);
  wire new_ev      = (|new_wake) || new_fail_ev;

  logic                prev_stop;
  wire stop_entry = mode == ips_pkg::IPS_MODE_STOP && !prev_stop;
  wire stop_ev    = stop_entry && (|wake_latch);

  // pulse sequencer
  ips_pkg::ips_state_t   state;
  ips_pkg::ips_state_t   next_state;
  logic [`IPS_CNT_W-1:0] cnt;
  logic                  pending;
  wire want  = (pending || new_ev || stop_ev) && irq_mode;
  // a waiting event starts right as the gap ends, no extra idle cycle
  wire gap_end = state == ips_pkg::IPS_GAP && cnt == GAP_CYC - 1'b1;
  wire start = (state == ips_pkg::IPS_IDLE || gap_end) && want;
  always_comb
  begin
    next_state = state;
    case (state)
      ips_pkg::IPS_IDLE:
        if (want)
          next_state = ips_pkg::IPS_PULSE;
      ips_pkg::IPS_PULSE:
        if (cnt == PULSE_CYC - 1'b1)
          next_state = ips_pkg::IPS_GAP;
      ips_pkg::IPS_GAP:
        if (gap_end)
          next_state = want ? ips_pkg::IPS_PULSE : ips_pkg::IPS_IDLE;
      default:
        next_state = ips_pkg::IPS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state     <= ips_pkg::IPS_IDLE;
      cnt       <= '0;
      pending   <= 1'b0;
      prev_stop <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= (next_state != state) ? '0 : cnt + 1'b1;
      prev_stop <= mode == ips_pkg::IPS_MODE_STOP;
      // events in quiet modes are not signalled later by pulse, save wake bits still latched at stop entry
      if (quiet_mode)
        pending <= 1'b0;
      else if (start)
        pending <= 1'b0;
      else if (new_ev || stop_ev)
        pending <= 1'b1;
    end
  end

  // outputs; mode is an input only, the pulse never drives it
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_out_n             <= 1'b1;
      irq_out_oe            <= 1'b0;
      wake_status           <= '0;
      fail_status           <= '0;
      wake_pin_level_status <= 1'b0;
      device_wakeup         <= 1'b0;
    end
    else
    begin
      irq_out_n  <= !(next_state == ips_pkg::IPS_PULSE);
      irq_out_oe <= !in_init; // pin sensed as strap during init
      if (start)
      begin
        wake_status <= wake_latch | new_wake;
        fail_status <= fail_latch | fail_event;
      end
      else
      begin
        wake_status <= wake_status & ~clear_wake;
        fail_status <= fail_status & ~clear_fail;
      end
      wake_pin_level_status <= wk_stable;
      device_wakeup <= (mode == ips_pkg::IPS_MODE_SLEEP ||
                        mode == ips_pkg::IPS_MODE_FAILSAFE) &&
                       (|new_wake);
    end
  end

  // helpers: low time of the current pulse, high time since the last one;
  // high_cnt saturates so a long idle stretch never wraps into a short gap
  logic [`IPS_CNT_W-1:0] low_cnt;
  logic [`IPS_CNT_W-1:0] high_cnt;
  logic                  seen_low;
  wire high_sat = high_cnt == '1;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_cnt  <= '0;
      high_cnt <= '0;
      seen_low <= 1'b0;
    end
    else
    begin
      low_cnt  <= irq_out_n ? '0 : low_cnt + 1'b1;
      high_cnt <= (!irq_out_n) ? '0 : (high_sat ? high_cnt : high_cnt + 1'b1);
      seen_low <= seen_low || !irq_out_n;
    end
  end

  chk_pulse_not_long: assert property (
    !irq_out_n |-> low_cnt < PULSE_CYC)
    else $error("interrupt pulse too long");
  chk_pulse_full_width: assert property (
    $rose(irq_out_n) |-> $past(low_cnt) == PULSE_CYC - 1'b1)
    else $error("interrupt pulse width wrong");
  chk_gap_held: assert property (
    $rose(irq_out_n) |-> irq_out_n [*8])
    else $error("gap too short");
  // the first pulse after reset has no gap before it to judge
  chk_gap_full_width: assert property (
    $fell(irq_out_n) && seen_low |-> high_cnt >= GAP_CYC)
    else $error("gap between pulses too short");
  chk_quiet_no_pulse: assert property (
    quiet_mode && state == ips_pkg::IPS_IDLE |=> irq_out_n)
    else $error("pulse in quiet mode");
  chk_pending_served: assert property (
    pending && irq_mode && (state == ips_pkg::IPS_IDLE || gap_end)
      |=> !irq_out_n)
    else $error("pending event not pulsed");
  chk_stop_entry_irq: assert property (
    stop_ev && state == ips_pkg::IPS_IDLE |=> !irq_out_n)
    else $error("stop entry did not interrupt");
  chk_status_at_fall: assert property (
    $fell(irq_out_n) |->
      (wake_status & $past(wake_latch)) == $past(wake_latch))
    else $error("status not updated at fall");
  chk_wake_class: assert property (
    !class_global && new_wake == '0 && state == ips_pkg::IPS_IDLE
      && !pending && !stop_ev |=> irq_out_n)
    else $error("wake class pulsed without wake");
  chk_latch_held: assert property (
    wake_latch.can && !clear_wake.can |=> wake_latch.can)
    else $error("wake latch lost");
  cov_pulse: cover property ($rose(irq_out_n));
  cov_pending: cover property (state == ips_pkg::IPS_GAP && new_ev);
  cov_hv_wake: cover property (wk_done);
  cov_cfg: cover property ($changed(hw_config_sel));

endmodule
`default_nettype wire

// ===== include/ips_map.svh
`ifndef IPS_MAP_SVH
`define IPS_MAP_SVH
// times in ns, clock period in ns
`define IPS_CLK_PERIOD_NS    5
`define IPS_PULSE_NS         100000
`define IPS_GAP_NS           100000
`define IPS_WAKE_FILT_NS     16000
`define IPS_CFG_FILT_NS      10000
`define IPS_PULSE_CYC        (`IPS_PULSE_NS / `IPS_CLK_PERIOD_NS)
`define IPS_GAP_CYC          (`IPS_GAP_NS / `IPS_CLK_PERIOD_NS)
`define IPS_WAKE_FILT_CYC    (`IPS_WAKE_FILT_NS / `IPS_CLK_PERIOD_NS)
`define IPS_CFG_FILT_CYC     (`IPS_CFG_FILT_NS / `IPS_CLK_PERIOD_NS)
`define IPS_CNT_W            15
`define IPS_FAIL_W           8
`endif

// ===== include/ips_pkg.sv
package ips_pkg;
  typedef enum logic [2:0] {
    IPS_MODE_INIT,
    IPS_MODE_NORMAL,
    IPS_MODE_STOP,
    IPS_MODE_RESTART,
    IPS_MODE_FAILSAFE,
    IPS_MODE_SLEEP
  } ips_mode_t;

  // wake enables and events share one layout
  typedef struct packed {
    logic can;
    logic hv_pin;
    logic timer;
    logic gpio;
  } ips_wake_t;

  typedef enum {
    IPS_IDLE,
    IPS_PULSE,
    IPS_GAP
  } ips_state_t;
endpackage
